// [logic/scd_pkg.sv]
// Package of the sampling clock delay and ramp block: register map, reset values and cycle counts.
// Assumes one control clock and a plain register port with read data one cycle after the strobe.
package scd_pkg;

  // Register port geometry
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0]  OFS_CTRL          = 8'h00;
  localparam logic [7:0]  OFS_COARSE        = 8'h04;
  localparam logic [7:0]  OFS_FINE          = 8'h08;
  localparam logic [7:0]  OFS_STATUS        = 8'h0C;
  localparam logic [7:0]  OFS_SR_PERIOD     = 8'h10;
  localparam logic [7:0]  OFS_SR_MEASURED   = 8'h14;

  // Control register fields
  localparam int          CTRL_SINGLE_BIT   = 0;
  localparam int          CTRL_RAMP_EN_BIT  = 1;
  localparam int          CTRL_RAMP_FAST_BIT = 2;
  localparam int          CTRL_INVERT_BIT   = 3;

  // Status register fields
  localparam int          STAT_APPLIED_LSB  = 0;
  localparam int          STAT_BUSY_BIT     = 8;
  localparam int          STAT_SEEN_BIT     = 9;
  localparam int          STAT_PERIODIC_BIT = 10;
  localparam int          STAT_FREQ_OK_BIT  = 11;

  // Delay code geometry: 256 settings each
  localparam int          CODE_W            = 8;
  localparam int          CODE_SETTINGS     = 256;
  localparam int          PERIOD_W          = 16;

  // Reset values
  localparam logic [3:0]  CTRL_RST          = 4'h0;
  localparam logic [7:0]  COARSE_RST        = 8'h00;
  localparam logic [7:0]  FINE_RST          = 8'h00;
  localparam logic [15:0] SR_PERIOD_RST     = 16'h0000;

  // Ramp timing: steps per window of device clock cycles
  localparam int          RAMP_WINDOW_CYC   = 256;
  localparam int          RAMP_SLOW_STEPS   = 1;
  localparam int          RAMP_FAST_STEPS   = 4;

  // Timing reference capture window in device clock edges per mode
  localparam logic [1:0]  WINDOW_DUAL       = 2'h1;
  localparam logic [1:0]  WINDOW_SINGLE     = 2'h2;

  typedef enum logic { SCD_MODE_DUAL, SCD_MODE_SINGLE } scd_mode_e;

endpackage

// [logic/scd_ramp.sv]
// Coarse delay ramp engine: walks the applied code toward the target one step at a time.
// Assumes the target is held stable by the register file and load_i pulses on each target write.
`timescale 1ns/1ps
module scd_ramp #(
  parameter int W     = 8,
  parameter int WIN   = 256,
  parameter int SLOW  = 1,
  parameter int FAST  = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] target_i,
  input  wire logic         ramp_en_i,
  input  wire logic         fast_i,
  output logic      [W-1:0] applied_o,
  output logic              busy_o
);
  localparam int           CW        = $clog2(WIN);
  localparam logic [CW-1:0] SLOW_MASK = CW'(WIN / SLOW - 1);
  localparam logic [CW-1:0] FAST_MASK = CW'(WIN / FAST - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [W-1:0]  applied_q;
  logic [W-1:0]  applied_d;
  wire           tick_slow  = (cnt_q & SLOW_MASK) == SLOW_MASK;
  wire           tick_fast  = (cnt_q & FAST_MASK) == FAST_MASK;
  wire           tick       = fast_i ? tick_fast : tick_slow;
  wire           at_target  = applied_q == target_i;
  wire           go_up      = target_i > applied_q;

  // A fresh write restarts the step window so the first step is a full interval away
  assign cnt_d = (load_i || at_target) ? '0 : cnt_q + CW'(1);
  assign busy_o    = ramp_en_i && !at_target;
  assign applied_o = applied_q;

  always_comb begin
    applied_d = applied_q;
    if (!ramp_en_i) begin
      applied_d = target_i;
    end else if (tick && !at_target && !load_i) begin
      applied_d = go_up ? applied_q + W'(1) : applied_q - W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q     <= '0;
      applied_q <= '0;
    end else begin
      cnt_q     <= cnt_d;
      applied_q <= applied_d;
    end
  end

  a_ramp_single_step: assert property (@(posedge clk_i) disable iff (rst_i)
    ramp_en_i && $past(ramp_en_i) && (applied_q != $past(applied_q)) |->
      (applied_q == $past(applied_q) + W'(1)) || (applied_q == $past(applied_q) - W'(1)))
    else $error("ramp moved more than one step");

  a_ramp_no_overshoot: assert property (@(posedge clk_i) disable iff (rst_i)
    ramp_en_i && at_target && !load_i ##1 ramp_en_i && $stable(target_i) |-> $stable(applied_q))
    else $error("ramp left its target");

  a_ramp_slow_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    ramp_en_i && !fast_i && $changed(applied_q) && $past(ramp_en_i) |->
      $past(cnt_q) == CW'(WIN - 1))
    else $error("slow ramp stepped off its interval");

  a_ramp_fast_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    ramp_en_i && fast_i && $changed(applied_q) && $past(ramp_en_i) |->
      ($past(cnt_q) & FAST_MASK) == FAST_MASK)
    else $error("fast ramp stepped off its interval");

endmodule // scd_ramp

// [logic/scd_clock_delay.sv]
// Sampling clock control: edge selection, timing reference qualification and aperture delay with ramp.
// Assumes one 200 MHz control clock, synchronous inputs and a plain register port without wait states.
// Summary of operation
// - Dual mode samples on rising edge only
// - Single mode samples on both clock edges
// - One clock drives core, processing, lanes
// - Reference captured on a deterministic edge
// - Invert bit adds half-period delay
// - Coarse and fine each have 256 settings
// - Delay parts independent and additive
// - All internal clocks shift by programmed delay
// - Live rewrites allowed; ramp lowers link risk
// - Ramp steps applied coarse toward target
// - Slow one step, fast four per 256
// - Coarse write while enabled restarts ramp
// - Single mode doubles reference capture window
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module scd_clock_delay
  import scd_pkg::*;
#(
  parameter int RAMP_WIN   = scd_pkg::RAMP_WINDOW_CYC,
  parameter int RAMP_SLOW  = scd_pkg::RAMP_SLOW_STEPS,
  parameter int RAMP_FAST  = scd_pkg::RAMP_FAST_STEPS
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  // Register port
  input  wire logic [scd_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [scd_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [scd_pkg::DATA_W-1:0]   reg_rdata_o,
  // Timing reference from the clock generator
  input  wire logic                         sysref_i,
  // Sampling edge selection
  output logic                              sample_rise_en_o,
  output logic                              sample_fall_en_o,
  // Delay applied to every internal clock
  output logic                              clock_invert_half_period_o,
  output logic      [scd_pkg::CODE_W-1:0]   coarse_delay_code_o,
  output logic      [scd_pkg::CODE_W-1:0]   fine_delay_code_o,
  output logic      [2*scd_pkg::CODE_W:0]   core_clk_delay_o,
  output logic      [2*scd_pkg::CODE_W:0]   dsp_clk_delay_o,
  output logic      [2*scd_pkg::CODE_W:0]   lane_clk_delay_o,
  output logic      [2*scd_pkg::CODE_W:0]   sysref_clk_delay_o,
  output logic                              ramp_busy_o,
  // Timing reference capture
  output logic                              sysref_capture_o,
  output logic      [1:0]                   sysref_window_o,
  output logic                              sysref_periodic_o,
  output logic                              sysref_freq_ok_o
);
  import scd_pkg::*;

  localparam int DW = 2 * CODE_W + 1;

  // ---------------------------------------------------------------- register decode
  wire sel_ctrl      = reg_addr_i == OFS_CTRL;
  wire sel_coarse    = reg_addr_i == OFS_COARSE;
  wire sel_fine      = reg_addr_i == OFS_FINE;
  wire sel_status    = reg_addr_i == OFS_STATUS;
  wire sel_period    = reg_addr_i == OFS_SR_PERIOD;
  wire sel_measured  = reg_addr_i == OFS_SR_MEASURED;

  wire wr_ctrl       = reg_wr_i && sel_ctrl;
  wire wr_coarse     = reg_wr_i && sel_coarse;
  wire wr_fine       = reg_wr_i && sel_fine;
  wire wr_period     = reg_wr_i && sel_period;

  // ---------------------------------------------------------------- control state
  logic [3:0]          ctrl_q;
  logic [CODE_W-1:0]   coarse_target_q;
  logic [CODE_W-1:0]   fine_q;
  logic [PERIOD_W-1:0] sr_period_q;
  logic [DATA_W-1:0]   rdata_q;
  logic [DATA_W-1:0]   rdata_d;

  wire                 single_mode  = ctrl_q[CTRL_SINGLE_BIT];
  wire                 ramp_enable_bit   = ctrl_q[CTRL_RAMP_EN_BIT];
  wire                 ramp_speed_select = ctrl_q[CTRL_RAMP_FAST_BIT];
  wire                 invert_bit   = ctrl_q[CTRL_INVERT_BIT];
  scd_mode_e           mode;

  assign mode = single_mode ? SCD_MODE_SINGLE : SCD_MODE_DUAL;

  // Delay fields live in separate registers so each can be rewritten alone
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q          <= CTRL_RST;
      coarse_target_q <= COARSE_RST;
      fine_q          <= FINE_RST;
      sr_period_q     <= SR_PERIOD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i[3:0];
      end
      if (wr_coarse) begin
        coarse_target_q <= reg_wdata_i[CODE_W-1:0];
      end
      if (wr_fine) begin
        fine_q <= reg_wdata_i[CODE_W-1:0];
      end
      if (wr_period) begin
        sr_period_q <= reg_wdata_i[PERIOD_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------- coarse ramp
  logic [CODE_W-1:0] coarse_applied;
  logic              ramp_busy;

  scd_ramp #(
    .W     (CODE_W),
    .WIN   (RAMP_WIN),
    .SLOW  (RAMP_SLOW),
    .FAST  (RAMP_FAST)
  ) u_ramp (
    .clk_i     (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (wr_coarse),
    .target_i  (coarse_target_q),
    .ramp_en_i (ramp_enable_bit),
    .fast_i    (ramp_speed_select),
    .applied_o (coarse_applied),
    .busy_o    (ramp_busy)
  );

  // ---------------------------------------------------------------- applied delay
  // One delay word feeds every internal clock so core, processing and lanes stay aligned
  logic [DW-1:0] delay_word_q;
  wire  [DW-1:0] delay_word_d = {invert_bit, coarse_applied, fine_q};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      delay_word_q <= '0;
    end else begin
      delay_word_q <= delay_word_d;
    end
  end

  assign clock_invert_half_period_o = delay_word_q[DW-1];
  assign coarse_delay_code_o        = delay_word_q[DW-2:CODE_W];
  assign fine_delay_code_o          = delay_word_q[CODE_W-1:0];
  assign core_clk_delay_o           = delay_word_q;
  assign dsp_clk_delay_o            = delay_word_q;
  assign lane_clk_delay_o           = delay_word_q;
  assign sysref_clk_delay_o         = delay_word_q;
  assign ramp_busy_o                = ramp_busy;

  // ---------------------------------------------------------------- sampling edges
  logic rise_en_q;
  logic fall_en_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_en_q <= 1'b1;
      fall_en_q <= 1'b0;
    end else begin
      rise_en_q <= 1'b1;
      fall_en_q <= mode == SCD_MODE_SINGLE;
    end
  end

  assign sample_rise_en_o = rise_en_q;
  assign sample_fall_en_o = fall_en_q;

  // ---------------------------------------------------------------- timing reference
  logic                sr_prev_q;
  logic                capture_q;
  logic [1:0]          window_q;
  logic [PERIOD_W-1:0] sr_cnt_q;
  logic [PERIOD_W-1:0] sr_measured_q;
  logic                sr_seen_q;
  logic                sr_periodic_q;
  logic                sr_freq_ok_q;

  // Capture is taken on the first clock edge that sees the reference high
  wire sr_rise      = sysref_i && !sr_prev_q;
  wire cnt_sat      = &sr_cnt_q;
  wire period_match = (sr_period_q != '0) && (sr_cnt_q + PERIOD_W'(1) == sr_period_q);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sr_prev_q     <= 1'b0;
      capture_q     <= 1'b0;
      window_q      <= WINDOW_DUAL;
      sr_cnt_q      <= '0;
      sr_measured_q <= '0;
      sr_seen_q     <= 1'b0;
      sr_periodic_q <= 1'b0;
      sr_freq_ok_q  <= 1'b0;
    end else begin
      sr_prev_q <= sysref_i;
      capture_q <= sr_rise;
      window_q  <= single_mode ? WINDOW_SINGLE : WINDOW_DUAL;
      if (sr_rise) begin
        sr_cnt_q  <= '0;
        sr_seen_q <= 1'b1;
        if (sr_seen_q) begin
          sr_measured_q <= sr_cnt_q + PERIOD_W'(1);
          sr_periodic_q <= 1'b1;
          sr_freq_ok_q  <= period_match;
        end
      end else if (!cnt_sat) begin
        sr_cnt_q <= sr_cnt_q + PERIOD_W'(1);
      end else begin
        // No second edge inside the counter range: treat it as a lone pulse
        sr_periodic_q <= 1'b0;
        sr_freq_ok_q  <= 1'b0;
      end
    end
  end

  assign sysref_capture_o  = capture_q;
  assign sysref_window_o   = window_q;
  assign sysref_periodic_o = sr_periodic_q;
  assign sysref_freq_ok_o  = sr_freq_ok_q;

  // ---------------------------------------------------------------- read path
  wire [DATA_W-1:0] status_word = DATA_W'({sr_freq_ok_q, sr_periodic_q, sr_seen_q, ramp_busy, coarse_applied});
  wire [DATA_W-1:0] rd_mux =
      sel_ctrl     ? DATA_W'(ctrl_q)          :
      sel_coarse   ? DATA_W'(coarse_target_q) :
      sel_fine     ? DATA_W'(fine_q)          :
      sel_status   ? status_word              :
      sel_period   ? DATA_W'(sr_period_q)     :
      sel_measured ? DATA_W'(sr_measured_q)   : '0;

  // Read data stands only in the cycle after the strobe
  assign rdata_d = reg_rd_i ? rd_mux : '0;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ---------------------------------------------------------------- checks
  a_edge_dual_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !single_mode ##1 !single_mode |-> sample_rise_en_o && !sample_fall_en_o)
    else $error("dual mode must sample on the rising edge only");

  a_edge_single_both: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    single_mode |=> sample_rise_en_o && sample_fall_en_o)
    else $error("single mode must sample on both edges");

  a_clock_shift_common: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    core_clk_delay_o == dsp_clk_delay_o && dsp_clk_delay_o == lane_clk_delay_o &&
    lane_clk_delay_o == sysref_clk_delay_o)
    else $error("internal clocks carry different delays");

  a_invert_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_ctrl ##1 1'b1 |=> clock_invert_half_period_o == $past(reg_wdata_i[CTRL_INVERT_BIT], 2))
    else $error("invert bit not applied two cycles after write");

  a_fine_direct: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_fine |-> ##2 fine_delay_code_o == $past(reg_wdata_i[CODE_W-1:0], 2))
    else $error("fine delay not applied independently");

  a_coarse_jump: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ramp_enable_bit && wr_coarse ##1 !ramp_enable_bit ##1 !ramp_enable_bit ##1 1'b1 |->
      coarse_delay_code_o == $past(reg_wdata_i[CODE_W-1:0], 3))
    else $error("coarse delay did not jump with ramp off");

  sequence s_new_ramp;
    ramp_enable_bit && wr_coarse && (reg_wdata_i[CODE_W-1:0] != coarse_applied);
  endsequence

  a_coarse_write_ramp: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_new_ramp ##1 ramp_enable_bit |-> ramp_busy ##1 $stable(coarse_delay_code_o))
    else $error("coarse write did not start a gradual ramp");

  a_sysref_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !sysref_i ##1 sysref_i |=> sysref_capture_o ##1 !sysref_capture_o)
    else $error("reference edge not captured as one pulse");

  a_window_single: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    single_mode |=> sysref_window_o == WINDOW_SINGLE)
    else $error("single mode capture window not doubled");

  a_read_one_cycle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data stood outside its cycle");

  a_fall_dual_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !single_mode |=> !sample_fall_en_o)
    else $error("falling edge used in dual mode");

  a_window_dual: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !single_mode |=> sysref_window_o == WINDOW_DUAL)
    else $error("dual mode capture window wrong");

  a_capture_edge: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sysref_capture_o |-> $past(sysref_i) && !$past(sr_prev_q))
    else $error("capture without a reference edge");

  a_periodic_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(sysref_periodic_o) |-> $past(sr_rise) && $past(sr_seen_q))
    else $error("periodic flag set without a second edge");

  a_freq_ok_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(sysref_freq_ok_o) |-> $past(sr_rise) && $past(period_match))
    else $error("frequency flag set without a period match");

  a_measured_gap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sr_rise && sr_seen_q |=> sr_measured_q == $past(sr_cnt_q) + PERIOD_W'(1))
    else $error("measured period is not the edge gap");

  a_fine_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !wr_fine |=> ##1 $stable(fine_delay_code_o))
    else $error("fine delay moved without a write");

  a_ramp_off_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ramp_enable_bit |=> coarse_applied == $past(coarse_target_q))
    else $error("coarse delay did not follow target with ramp off");

  a_ramp_load_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ramp_enable_bit && wr_coarse |=> $stable(coarse_applied))
    else $error("coarse write did not restart the step interval");

  sequence s_ramp_step;
    ramp_enable_bit && $past(ramp_enable_bit) && $changed(coarse_applied);
  endsequence

  a_step_toward: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_ramp_step |->
      ($past(coarse_target_q) > $past(coarse_applied)) == (coarse_applied > $past(coarse_applied)))
    else $error("ramp stepped away from its target");

  a_status_applied: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_rd_i && sel_status |=> reg_rdata_o[CODE_W-1:0] == $past(coarse_applied))
    else $error("status does not show the applied coarse code");

endmodule // scd_clock_delay

// [tb/scd_refgen.sv]
// Clock generator model: drives the timing reference as lone pulses or as a periodic signal.
// Assumes the bench clock and reset; its output changes only just after a rising edge.
`timescale 1ns/1ps
module scd_refgen (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        shot_i,
  input  wire logic [15:0] period_i,
  output logic             sysref_o
);
  logic [15:0] cnt_q;
  logic [1:0]  shot_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 16'h0000;
      shot_q <= 2'h0;
    end else begin
      cnt_q  <= (!run_i || cnt_q >= period_i - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      shot_q <= shot_i ? 2'h2 : ((shot_q != 2'h0) ? shot_q - 2'h1 : 2'h0);
    end
  end

  // Two-cycle high per period, or one lone two-cycle pulse, launched just after an edge
  assign sysref_o = (run_i && cnt_q < 16'h0002) || (shot_q != 2'h0);
endmodule // scd_refgen

// [tb/sampling_clock_delay_ramp_bench.sv]
// Self-checking bench of the sampling clock delay block with the clock generator model.
// Assumes the design package; the ramp window is shortened to 16 cycles.
`timescale 1ns/1ps
module sampling_clock_delay_ramp_bench;
  import scd_pkg::*;
  localparam int WIN = 16;
  logic              ref_clk_i   = 1'b0;
  logic              rst_i       = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i  = 8'h00;
  logic [DATA_W-1:0] reg_wdata_i = 32'h0;
  logic              reg_wr_i    = 1'b0;
  logic              reg_rd_i    = 1'b0;
  logic              run         = 1'b0;
  logic              shot        = 1'b0;
  logic [15:0]       period      = 16'h0000;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              sysref_i, rise_en, fall_en, inv, busy, cap, periodic, freq_ok;
  logic [7:0]        coarse, fine;
  logic [16:0]       d_core, d_dsp, d_lane, d_sr;
  logic [1:0]        window;
  int                errors = 0;
  int                tests_run = 0;
  int                caps = 0;

  scd_clock_delay #(.RAMP_WIN(WIN), .RAMP_SLOW(1), .RAMP_FAST(4)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sysref_i(sysref_i),
    .sample_rise_en_o(rise_en), .sample_fall_en_o(fall_en), .clock_invert_half_period_o(inv),
    .coarse_delay_code_o(coarse), .fine_delay_code_o(fine), .core_clk_delay_o(d_core),
    .dsp_clk_delay_o(d_dsp), .lane_clk_delay_o(d_lane), .sysref_clk_delay_o(d_sr),
    .ramp_busy_o(busy), .sysref_capture_o(cap), .sysref_window_o(window),
    .sysref_periodic_o(periodic), .sysref_freq_ok_o(freq_ok));

  scd_refgen gen (.clk_i(ref_clk_i), .rst_i(rst_i), .run_i(run), .shot_i(shot), .period_i(period),
                  .sysref_o(sysref_i));

  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (cap === 1'b1) caps <= caps + 1;

  function automatic logic [16:0] exp_delay(input logic i, input logic [7:0] c, input logic [7:0] f);
    return {i, c, f};
  endfunction
  // Reference period in clock cycles for a given coding divider
  function automatic logic [15:0] ref_period(input int div, input int r);
    return 16'(div / r);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic next_step(output int n);
    logic [7:0] prev;
    #1;
    prev = coarse;
    n = 0;
    while (coarse === prev && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic ramp(input logic fast, input logic [7:0] from, input logic [7:0] to);
    int n;
    int k;
    logic [7:0] prev;
    logic [31:0] d;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COARSE, {24'h0, from});
    wr(OFS_CTRL, {29'h0, fast, 2'h2});
    cyc(2);
    chk(32'(coarse), 32'(from), "ramp start");
    wr(OFS_COARSE, {24'h0, to});
    cyc(1);
    chk(32'(busy), 32'h1, "busy");
    rd(OFS_STATUS, d);
    chk(32'(d[STAT_BUSY_BIT]), 32'h1, "status busy");
    k = 0;
    while (coarse !== to && k < 300) begin
      prev = coarse;
      next_step(n);
      chk(32'(coarse), 32'((to > prev) ? prev + 8'h01 : prev - 8'h01), "step");
      if (k > 1) chk(32'(n), 32'(fast ? WIN / 4 : WIN), "step spacing");
      k++;
    end
    cyc(2 * WIN);
    chk(32'(coarse), 32'(to), "no overshoot");
    chk(32'(busy), 32'h0, "idle");
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is near 2700 cycles; the limit leaves ample margin
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    errors++;
    give_verdict();
  end

  initial begin
    logic [31:0] d;
    logic        i;
    logic [7:0]  c;
    logic [7:0]  f;
    int          n;
    void'($urandom(66));
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk(32'(rise_en), 32'h1, "dual rise");
    chk(32'(fall_en), 32'h0, "dual fall");
    chk(32'(window), 32'(WINDOW_DUAL), "dual window");
    wr(OFS_CTRL, 32'h1);
    cyc(2);
    chk(32'(rise_en), 32'h1, "single rise");
    chk(32'(fall_en), 32'h1, "single fall");
    chk(32'(window), 32'(WINDOW_SINGLE), "single window");
    rd(8'h20, d);
    chk(d, 32'h0, "unmapped read");
    rd(OFS_CTRL, d);
    chk(d & 32'hF, 32'h1, "ctrl readback");
    cyc(1);
    chk(reg_rdata_o, 32'h0, "read data one cycle");
    $display("test modes done");

    for (int t = 0; t < 8; t++) begin
      i = (t == 0) ? 1'b1 : ((t == 1) ? 1'b0 : 1'($urandom));
      c = (t == 0) ? 8'hFF : ((t == 1) ? 8'h00 : 8'($urandom));
      f = (t == 0) ? 8'hFF : ((t == 1) ? 8'h00 : 8'($urandom));
      wr(OFS_CTRL, {28'h0, i, 3'h0});
      wr(OFS_COARSE, {24'h0, c});
      wr(OFS_FINE, {24'h0, f});
      wr(8'h20, 32'hFFFF_FFFF);
      cyc(2);
      chk(32'(inv), 32'(i), "invert");
      chk(32'(fine), 32'(f), "fine");
      chk(32'(coarse), 32'(c), "coarse");
      chk(32'(d_core), 32'(exp_delay(i, c, f)), "core delay");
      chk(32'(d_dsp), 32'(exp_delay(i, c, f)), "dsp delay");
      chk(32'(d_lane), 32'(exp_delay(i, c, f)), "lane delay");
      chk(32'(d_sr), 32'(exp_delay(i, c, f)), "reference delay");
      rd(OFS_STATUS, d);
      chk(d & 32'hFF, 32'(c), "status applied");
    end
    $display("test delays done");

    ramp(1'b0, 8'h10, 8'h14);
    ramp(1'b1, 8'hFA, 8'hF0);
    $display("test ramps done");

    wr(OFS_CTRL, 32'h0);
    wr(OFS_COARSE, 32'h5);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_COARSE, 32'hA);
    next_step(n);
    chk(32'(coarse), 32'h6, "ramp up");
    cyc(WIN / 2);
    wr(OFS_COARSE, 32'h2);
    next_step(n);
    chk(32'(n >= WIN - 3), 32'h1, "ramp restarted");
    chk(32'(coarse), 32'h5, "ramp reversed");
    $display("test ramp restart done");

    n = caps;
    @(posedge ref_clk_i);
    shot <= 1'b1;
    @(posedge ref_clk_i);
    shot <= 1'b0;
    cyc(10);
    chk(32'(caps - n), 32'h1, "one capture per pulse");
    rd(OFS_STATUS, d);
    chk(32'(d[STAT_SEEN_BIT]), 32'h1, "seen");
    for (int t = 0; t < 2; t++) begin
      c = 8'(t);
      period = (t == 0) ? ref_period(10 * 2 * 4 * 1, 2) : ref_period(66 * 32 * 1 * 1, 4);
      wr(OFS_SR_PERIOD, {16'h0, period});
      @(posedge ref_clk_i);
      run <= 1'b1;
      cyc(3 * period + 5);
      chk(32'(periodic), 32'h1, "periodic");
      chk(32'(freq_ok), 32'h1, "frequency match");
      rd(OFS_SR_MEASURED, d);
      chk(d & 32'hFFFF, 32'(period), "measured period");
      wr(OFS_SR_PERIOD, {16'h0, period + 16'h0001});
      cyc(period + 5);
      chk(32'(freq_ok), 32'h0, "frequency mismatch");
      @(posedge ref_clk_i);
      run <= 1'b0;
      cyc(4);
    end
    $display("test reference done");
    give_verdict();
  end
endmodule // sampling_clock_delay_ramp_bench
